// file: fpep_axil.sv
// axi4-lite slave for the protection registers
// assumes a single-outstanding master; answers one cycle after both write halves arrive
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module fpep_axil
  import fpep_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  fpep_cfg_if.slave        cfg
);
  typedef struct packed {
    logic        aw_got;
    logic [3:0]  awaddr;
    logic        w_got;
    logic [7:0]  wdata;
    logic        wlane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } fpep_axs_t;

  fpep_axs_t st_ff;
  fpep_axs_t nxt_st;
  logic      do_wr;
  logic      wr_ok;

  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rdata   = st_ff.rdata;

  assign do_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
  assign wr_ok = (st_ff.awaddr == FPEP_CTRL1_OFS) || (st_ff.awaddr == FPEP_CTRL2_OFS) ||
                 (st_ff.awaddr == FPEP_EBS_OFS) || (st_ff.awaddr == FPEP_STAT_OFS);
  // a write with byte lane 0 disabled changes nothing but is still answered okay
  assign cfg.wr_c1  = do_wr && st_ff.wlane && (st_ff.awaddr == FPEP_CTRL1_OFS);
  assign cfg.wr_c2  = do_wr && st_ff.wlane && (st_ff.awaddr == FPEP_CTRL2_OFS);
  assign cfg.wr_ebs = do_wr && st_ff.wlane && (st_ff.awaddr == FPEP_EBS_OFS);
  assign cfg.wdata  = st_ff.wdata;

  always_comb begin
    nxt_st = st_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = {s_axi_awaddr[3:2], 2'h0};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata[7:0];
      nxt_st.wlane = s_axi_wstrb[0];
    end
    if (do_wr) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = wr_ok ? FPEP_RESP_OKAY : FPEP_RESP_SLVERR;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = FPEP_RESP_OKAY;
      unique case ({s_axi_araddr[3:2], 2'h0})
        FPEP_CTRL1_OFS: nxt_st.rdata = {24'h000000, cfg.c1};
        FPEP_CTRL2_OFS: nxt_st.rdata = {24'h000000, cfg.c2};
        FPEP_EBS_OFS:   nxt_st.rdata = {24'h000000, cfg.ebs};
        FPEP_STAT_OFS:  nxt_st.rdata = {26'h0000000, cfg.stat};
        default: begin
          nxt_st.rdata = 32'h00000000;
          nxt_st.rresp = FPEP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// file: fpep_pkg.sv
// package for flash program/erase protection: register map, field positions, reset values
// assumes a 32-bit axi4-lite register bus and a 20 MHz core clock
package fpep_pkg;
  // register byte offsets
  localparam logic [3:0] FPEP_CTRL1_OFS = 4'h0;
  localparam logic [3:0] FPEP_CTRL2_OFS = 4'h4;
  localparam logic [3:0] FPEP_EBS_OFS   = 4'h8;
  localparam logic [3:0] FPEP_STAT_OFS  = 4'hC;
  // flash_control_reg_one fields
  localparam int FPEP_C1_PROG  = 0;
  localparam int FPEP_C1_ERASE = 1;
  localparam int FPEP_C1_PGM_VFY = 2;
  localparam int FPEP_C1_ERS_VFY = 3;
  localparam int FPEP_C1_WREN    = 6;
  // flash_control_reg_two fields
  localparam int FPEP_C2_PGM_SET = 0;
  localparam int FPEP_C2_ERS_SET = 1;
  localparam int FPEP_C2_ERR     = 7;
  // status register fields
  localparam int FPEP_ST_HWP  = 0;
  localparam int FPEP_ST_SWP  = 1;
  localparam int FPEP_ST_ERRP = 2;
  localparam int FPEP_ST_PGM  = 3;
  localparam int FPEP_ST_ERS  = 4;
  localparam int FPEP_ST_VFY  = 5;
  // register widths and reset values
  localparam int FPEP_NBLK = 8;
  localparam logic [7:0] FPEP_C1_RST  = 8'h00;
  localparam logic [7:0] FPEP_C2_RST  = 8'h00;
  localparam logic [7:0] FPEP_EBS_RST = 8'h00;
  // writable bit masks
  localparam logic [7:0] FPEP_C1_WMASK = 8'h4F;
  localparam logic [7:0] FPEP_C2_WMASK = 8'h03;
  // axi responses
  localparam logic [1:0] FPEP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] FPEP_RESP_SLVERR = 2'h2;
  // timing of the external reset, kept for reference by the surroundings
  localparam int FPEP_CLK_HZ          = 20000000;
  localparam int FPEP_RST_RUN_CYC     = 10;
  localparam int FPEP_RST_PWRON_MS    = 40;
  localparam int FPEP_RST_PWRON_CYC   = (FPEP_RST_PWRON_MS * (FPEP_CLK_HZ / 1000));
endpackage

// file: fpep_cfg_if.sv
// carrier between the register slave and the protection core
// assumes both ends on core_clk
`timescale 1ns/1ps
interface fpep_cfg_if;
  logic       wr_c1;
  logic       wr_c2;
  logic       wr_ebs;
  logic [7:0] wdata;
  logic [7:0] c1;
  logic [7:0] c2;
  logic [7:0] ebs;
  logic [5:0] stat;
  modport slave (output wr_c1, output wr_c2, output wr_ebs, output wdata,
                 input c1, input c2, input ebs, input stat);
  modport core  (input wr_c1, input wr_c2, input wr_ebs, input wdata,
                 output c1, output c2, output ebs, output stat);
endinterface

// file: fpep_core.sv
// flash program/erase protection: hardware, software and error protection layers
// assumes cpu event strobes are on core_clk; the write-enable pin is asynchronous
`timescale 1ns/1ps
// Function
// - low write-enable pin clears control and block registers, keeps error flag, protects.
// - any reset or standby entry clears all registers and enters protection; here standby entry keeps the error flag set.
// - hardware protection blocks program, erase, verify and block selection.
// - software write-enable at zero protects all blocks, no program, erase, verify.
// - under software protection program or erase bit cannot start the mode.
// - erase allowed only on selected blocks; verify reads still allowed.
// - all-zero block select protects every block from program and erase.
// - error during program or erase sets error flag and error protection.
// - error keeps register contents but aborts program or erase at once.
// - in error protection program and erase bits cannot restart operation.
// - in error protection verify bits still settable and verify allowed.
// - flash read during program or erase sets error; data undefined.
// - non-reset exception start during program or erase sets error.
// - sleep instruction during program or erase sets error.
// - error protection persists until reset; writes never release it.
// - registers stay writable in error protection, cleared on software standby.
// - program or erase in progress exactly while program or erase bit is one.
// - no other abnormal operation sets the error flag.
// - no program or erase while write-enable pin is low.
// - modes entered through setup bits and program, erase, verify bits.
// - flash read data invalid while program or erase is under way.
module fpep_core
  import fpep_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 flash_write_enable_pin,
  input  wire logic                 standby_enter,
  input  wire logic                 soft_standby_enter,
  input  wire logic                 flash_read,
  input  wire logic                 exception_start,
  input  wire logic                 sleep_exec,
  fpep_cfg_if.core                  cfg,
  output logic                      program_drive,
  output logic                      erase_drive,
  output logic                      program_verify_drive,
  output logic                      erase_verify_drive,
  output logic [FPEP_NBLK-1:0]      erase_block_drive,
  output logic                      read_data_valid,
  output logic                      flash_error_flag
);
  typedef struct packed {
    logic       wen_meta;
    logic       wen_sync;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] ebs;
    logic       err_flag;
  } fpep_cst_t;

  fpep_cst_t st_ff;
  fpep_cst_t nxt_st;
  logic      hw_prot;
  logic      sw_prot;
  logic      busy;
  logic      err_evt;
  logic      blk_any;

  assign hw_prot = !st_ff.wen_sync;
  assign sw_prot = !st_ff.c1[FPEP_C1_WREN];
  assign blk_any = |st_ff.ebs;
  assign busy = st_ff.c1[FPEP_C1_PROG] || st_ff.c1[FPEP_C1_ERASE];
  assign err_evt = busy && (flash_read || exception_start || sleep_exec);

  always_comb begin
    nxt_st = st_ff;
    // the first stage feeds only the second
    nxt_st.wen_meta = flash_write_enable_pin;
    nxt_st.wen_sync = st_ff.wen_meta;
    if (cfg.wr_c1) begin
      nxt_st.c1 = cfg.wdata & FPEP_C1_WMASK;
    end
    if (cfg.wr_c2) begin
      nxt_st.c2 = cfg.wdata & FPEP_C2_WMASK;
    end
    if (cfg.wr_ebs) begin
      nxt_st.ebs = cfg.wdata;
    end
    if (err_evt) begin
      nxt_st.err_flag = 1'b1;
    end
    // pin low or either standby entry clears all but the flag
    if (hw_prot || standby_enter || soft_standby_enter) begin
      nxt_st.c1  = FPEP_C1_RST;
      nxt_st.c2  = FPEP_C2_RST;
      nxt_st.ebs = FPEP_EBS_RST;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    program_drive = st_ff.c1[FPEP_C1_PROG] && st_ff.c2[FPEP_C2_PGM_SET] && !hw_prot &&
                    !sw_prot && !st_ff.err_flag && !err_evt && blk_any;
    erase_drive   = st_ff.c1[FPEP_C1_ERASE] && st_ff.c2[FPEP_C2_ERS_SET] && !hw_prot &&
                    !sw_prot && !st_ff.err_flag && !err_evt && blk_any;
    program_verify_drive = st_ff.c1[FPEP_C1_PGM_VFY] && !hw_prot && !sw_prot;
    erase_verify_drive   = st_ff.c1[FPEP_C1_ERS_VFY] && !hw_prot && !sw_prot;
    erase_block_drive = erase_drive ? st_ff.ebs : '0;
    read_data_valid = !busy;
  end

  assign flash_error_flag = st_ff.err_flag;

  assign cfg.c1   = st_ff.c1;
  assign cfg.c2   = {st_ff.err_flag, st_ff.c2[6:0]};
  assign cfg.ebs  = st_ff.ebs;
  assign cfg.stat = {program_verify_drive || erase_verify_drive, erase_drive, program_drive,
                     st_ff.err_flag, sw_prot, hw_prot};
endmodule

// file: fpep_top.sv
// top of the flash program/erase protection block
// assumes cpu strobes on core_clk and an axi4-lite master on the same clock
`timescale 1ns/1ps
module fpep_top
  import fpep_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 flash_write_enable_pin,
  input  wire logic                 standby_enter,
  input  wire logic                 soft_standby_enter,
  input  wire logic                 flash_read,
  input  wire logic                 exception_start,
  input  wire logic                 sleep_exec,
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic                      program_drive,
  output logic                      erase_drive,
  output logic                      program_verify_drive,
  output logic                      erase_verify_drive,
  output logic [FPEP_NBLK-1:0]      erase_block_drive,
  output logic                      read_data_valid,
  output logic                      flash_error_flag
);
  fpep_cfg_if cfg ();

  fpep_axil u_axil (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .cfg           (cfg.slave)
  );

  fpep_core u_core (
    .core_clk               (core_clk),
    .rst_n                  (rst_n),
    .flash_write_enable_pin (flash_write_enable_pin),
    .standby_enter          (standby_enter),
    .soft_standby_enter     (soft_standby_enter),
    .flash_read             (flash_read),
    .exception_start        (exception_start),
    .sleep_exec             (sleep_exec),
    .cfg                    (cfg.core),
    .program_drive          (program_drive),
    .erase_drive            (erase_drive),
    .program_verify_drive   (program_verify_drive),
    .erase_verify_drive     (erase_verify_drive),
    .erase_block_drive      (erase_block_drive),
    .read_data_valid        (read_data_valid),
    .flash_error_flag       (flash_error_flag)
  );
endmodule

// file: fpep_chk.sv
// concurrent checks on the ports of the flash program/erase protection top
// assumes it is bound to fpep_top and that everything runs on core_clk
`timescale 1ns/1ps
module fpep_chk
  import fpep_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 flash_write_enable_pin,
  input wire logic                 standby_enter,
  input wire logic                 soft_standby_enter,
  input wire logic                 flash_read,
  input wire logic                 exception_start,
  input wire logic                 sleep_exec,
  input wire logic                 program_drive,
  input wire logic                 erase_drive,
  input wire logic                 program_verify_drive,
  input wire logic                 erase_verify_drive,
  input wire logic [FPEP_NBLK-1:0] erase_block_drive,
  input wire logic                 read_data_valid,
  input wire logic                 flash_error_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic evt_any;
  assign evt_any = flash_read | exception_start | sleep_exec;
  // read_data_valid low means a program or erase bit is set
  sequence s_busy_event;
    evt_any && !read_data_valid;
  endsequence
  // four samples cover the two-flop pin synchroniser plus the register clear
  sequence s_pin_low;
    !flash_write_enable_pin [*4];
  endsequence
  property p_err_set;
    s_busy_event |=> flash_error_flag;
  endproperty
  a_err_set: assert property (p_err_set) else $error("flag missed busy event");
  property p_err_cause;
    $rose(flash_error_flag) |-> $past(evt_any) && !$past(read_data_valid);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("flag set without cause");
  property p_sticky;
    flash_error_flag |=> flash_error_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without reset");
  property p_drop;
    s_busy_event |-> !program_drive && !erase_drive;
  endproperty
  a_drop: assert property (p_drop) else $error("drive kept in error cycle");
  property p_err_block;
    flash_error_flag |-> !program_drive && !erase_drive;
  endproperty
  a_err_block: assert property (p_err_block) else $error("drive while in error");
  property p_pin_off;
    s_pin_low |-> !(program_drive || erase_drive || program_verify_drive || erase_verify_drive);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("drive with pin low");
  property p_blk_off;
    !erase_drive |-> erase_block_drive == '0;
  endproperty
  a_blk_off: assert property (p_blk_off) else $error("block drive without erase");
  property p_blk_sel;
    erase_drive |-> erase_block_drive != '0;
  endproperty
  a_blk_sel: assert property (p_blk_sel) else $error("erase with no block");
  property p_busy_read;
    program_drive || erase_drive |-> !read_data_valid;
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("read valid while busy");
  property p_stby;
    standby_enter || soft_standby_enter |=> !program_drive && !erase_drive;
  endproperty
  a_stby: assert property (p_stby) else $error("drive after standby");
endmodule

// file: fpep_cpu.sv
// on-chip cpu model: an axi4-lite master that writes the protection registers
// assumes a single-clock slave; one write or one read at a time
`timescale 1ns/1ps
module fpep_cpu (
  input  wire logic        core_clk,
  output logic [3:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [3:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  // released addresses and write data show the inverse so stale values are never trusted; the write strobes keep their value
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata  <= d;
    s_axi_wstrb  <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule

// file: fpep_tb.sv
// self-checking bench for the flash program/erase protection top
// assumes the cpu model drives the register bus; events are driven here on core_clk
`timescale 1ns/1ps
module testbench
  import fpep_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        flash_write_enable_pin = 1'b1;
  logic        standby_enter = 1'b0;
  logic        soft_standby_enter = 1'b0;
  logic [2:0]  evt = 3'h0;
  wire         flash_read = evt[0];
  wire         exception_start = evt[1];
  wire         sleep_exec = evt[2];
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        program_drive, erase_drive, program_verify_drive, erase_verify_drive;
  logic        read_data_valid, flash_error_flag;
  logic [7:0]  erase_block_drive;
  int          n_mismatch = 0;
  int          num_checks = 0;
  wire  [13:0] outs = {program_drive, erase_drive, program_verify_drive, erase_verify_drive,
                       read_data_valid, flash_error_flag, erase_block_drive};
  always #25 core_clk = ~core_clk;
  fpep_top uut (.*);
  fpep_cpu cpu (.*);
  task automatic fail(input string m);
    n_mismatch++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk_out(input logic [13:0] e);
    #1;
    num_checks++;
    if (outs !== e) fail($sformatf("outputs %h expected %h", outs, e));
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e,
                        input logic [1:0] er = FPEP_RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    cpu.rd(a, d, r);
    num_checks++;
    if ({r, d} !== {er, e}) fail($sformatf("read %h gave %h %h", a, r, d));
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
    logic [1:0] r;
    cpu.wr(a, {24'h0, d}, s, r);
    num_checks++;
    if (r !== FPEP_RESP_OKAY) fail($sformatf("write %h resp %h", a, r));
  endtask
  task automatic chk_clr(input logic [7:0] c2);
    rd_chk(FPEP_CTRL1_OFS, 32'h0);
    rd_chk(FPEP_CTRL2_OFS, {24'h0, c2});
    rd_chk(FPEP_EBS_OFS, 32'h0);
  endtask
  task automatic pulse(input int i, input logic [13:0] e);
    @(posedge core_clk);
    evt[i] <= 1'b1;
    chk_out(e);
    @(posedge core_clk);
    evt <= 3'h0;
  endtask
  // hold reset low for n cycles (10 meets the in-operation minimum, the first call uses 4), then let the pin sync settle
  task automatic do_reset(input int n);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    fail("watchdog expired");
    close_out;
  end
  initial begin
    do_reset(4);
    chk_clr(8'h00);
    rd_chk(FPEP_STAT_OFS, 32'h2);
    // low address bits are dropped, so this reads flash_control_reg_one
    rd_chk(4'h2, 32'h0);
    // a write with lane 0 off must leave the block select untouched
    wr(FPEP_EBS_OFS, 8'hFF, 4'h0);
    rd_chk(FPEP_EBS_OFS, 32'h0);
    wr(FPEP_STAT_OFS, 8'hFF);
    rd_chk(FPEP_STAT_OFS, 32'h2);
    wr(FPEP_EBS_OFS, 8'h01);
    wr(FPEP_CTRL2_OFS, 8'h01);
    wr(FPEP_CTRL1_OFS, 8'h05);
    chk_out(14'h0000);
    wr(FPEP_CTRL1_OFS, 8'h40);
    wr(FPEP_EBS_OFS, 8'h00);
    wr(FPEP_CTRL1_OFS, 8'h41);
    chk_out(14'h0000);
    wr(FPEP_EBS_OFS, 8'h01);
    chk_out(14'h2000);
    pulse(0, 14'h0000);
    chk_out(14'h0100);
    rd_chk(FPEP_CTRL1_OFS, 32'h41);
    rd_chk(FPEP_CTRL2_OFS, 32'h81);
    wr(FPEP_CTRL1_OFS, 8'h41);
    chk_out(14'h0100);
    wr(FPEP_CTRL2_OFS, 8'h00);
    rd_chk(FPEP_CTRL2_OFS, 32'h80);
    wr(FPEP_CTRL1_OFS, 8'h44);
    chk_out(14'h0B00);
    @(posedge core_clk);
    flash_write_enable_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk_out(14'h0300);
    chk_clr(8'h80);
    wr(FPEP_CTRL1_OFS, 8'h44);
    chk_out(14'h0300);
    @(posedge core_clk);
    flash_write_enable_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    wr(FPEP_CTRL1_OFS, 8'h44);
    rd_chk(FPEP_CTRL1_OFS, 32'h44);
    soft_standby_enter <= 1'b1;
    @(posedge core_clk);
    soft_standby_enter <= 1'b0;
    chk_clr(8'h80);
    do_reset(10);
    chk_clr(8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(FPEP_CTRL1_OFS, 8'h40);
      pulse(i, 14'h0200);
      chk_out(14'h0200);
      wr(FPEP_EBS_OFS, 8'h04);
      wr(FPEP_CTRL2_OFS, 8'h02);
      wr(FPEP_CTRL1_OFS, 8'h42);
      chk_out(14'h1004);
      wr(FPEP_CTRL1_OFS, 8'h48);
      chk_out(14'h0600);
      wr(FPEP_CTRL1_OFS, 8'h42);
      pulse(i, 14'h0000);
      chk_out(14'h0100);
      wr(FPEP_CTRL1_OFS, 8'h48);
      chk_out(14'h0700);
      standby_enter <= 1'b1;
      @(posedge core_clk);
      standby_enter <= 1'b0;
      chk_clr(8'h80);
      do_reset(10);
    end
    close_out;
  end
endmodule
bind fpep_top fpep_chk u_chk (.*);
